/* core/pupo_top.sv */
// power-up reset, register preload and observe logic for a bank of macrocells
// assumes a classic wishbone master on mclk and a tester that drives io pins and test_mode
`timescale 1ns/1ps
module pupo_top (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  // wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // test mode select
  input  wire pupo_pkg::pupo_mode_t      test_mode,
  // product-term sums from the logic array
  input  wire logic [pupo_pkg::PUPO_N-1:0] pt_sum,
  // i/o pins
  input  wire logic [pupo_pkg::PUPO_N-1:0] io_in,
  output logic      [pupo_pkg::PUPO_N-1:0] io_out,
  output logic      [pupo_pkg::PUPO_N-1:0] io_oe_n,
  // feedback and status
  output logic      [pupo_pkg::PUPO_N-1:0] flop_fb,
  output logic                           por_done
);
  import pupo_pkg::*;

  typedef struct packed {
    logic                 ack;
    logic [31:0]          dat;
    logic [PUPO_N-1:0]    comb;
    logic [PUPO_N-1:0]    pol;
    logic [PUPO_N-1:0]    oe;
    logic [7:0]           async_cfg;
    logic [POR_CNT_W-1:0] por_cnt;
    logic                 por_done;
  } pupo_top_t;

  pupo_top_t         st;
  pupo_top_t         next_st;
  logic [PUPO_N-1:0] flops;
  logic [SRC_W-1:0]  arst_src;
  logic [SRC_W-1:0]  apre_src;
  logic              clr_all;
  logic              set_all;
  logic              req;

  // register index decode shared by read and write paths; 7 means unmapped
  function automatic logic [2:0] reg_sel(input logic [7:0] adr);
    case (adr)
      ADR_COMB:   reg_sel = 3'h0;
      ADR_POL:    reg_sel = 3'h1;
      ADR_OE:     reg_sel = 3'h2;
      ADR_ASYNC:  reg_sel = 3'h3;
      ADR_STATUS: reg_sel = 3'h4;
      ADR_FLOPS:  reg_sel = 3'h5;
      default:    reg_sel = 3'h7;
    endcase
  endfunction

  assign arst_src = st.async_cfg[ARST_SRC_LSB +: SRC_W];
  assign apre_src = st.async_cfg[APRE_SRC_LSB +: SRC_W];
  // a flop driving the async lines clears or sets the whole bank, preloaded or not
  assign clr_all  = st.por_done & st.async_cfg[ARST_EN_BIT] & flops[arst_src];
  assign set_all  = st.por_done & st.async_cfg[APRE_EN_BIT] & flops[apre_src];
  assign req      = wb_cyc_i & wb_stb_i;

  always_comb begin
    next_st = st;
    // power-up hold; the count is the worst-case bound, so done arrives no later than it
    if (!st.por_done) begin
      if (st.por_cnt == POR_LAST) begin
        next_st.por_done = 1'b1;
      end else begin
        next_st.por_cnt = st.por_cnt + POR_CNT_W'(1);
      end
    end
    // single-wait-state answer; ack drops the cycle after it is given
    next_st.ack = req & ~st.ack;
    if (req & ~st.ack) begin
      case (reg_sel(wb_adr_i))
        3'h0:    next_st.dat = {24'h000000, st.comb};
        3'h1:    next_st.dat = {24'h000000, st.pol};
        3'h2:    next_st.dat = {24'h000000, st.oe};
        3'h3:    next_st.dat = {24'h000000, st.async_cfg};
        3'h4:    next_st.dat = {29'h0, test_mode, st.por_done};
        3'h5:    next_st.dat = {24'h000000, flops};
        default: next_st.dat = 32'h00000000;
      endcase
    end
    // writes commit on the edge where ack is seen high
    if (req & st.ack & wb_we_i & wb_sel_i[0]) begin
      case (reg_sel(wb_adr_i))
        3'h0:    next_st.comb      = wb_dat_i[PUPO_N-1:0];
        3'h1:    next_st.pol       = wb_dat_i[PUPO_N-1:0];
        3'h2:    next_st.oe        = wb_dat_i[PUPO_N-1:0];
        3'h3:    next_st.async_cfg = wb_dat_i[7:0];
        default: next_st.dat       = st.dat;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '{ack: 1'b0, dat: 32'h00000000, comb: COMB_RST, pol: POL_RST, oe: OE_RST,
             async_cfg: ASYNC_RST, por_cnt: '0, por_done: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PUPO_N; gi++) begin : g_cell
      pupo_cell u_cell (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .mode     (test_mode),
        .por_busy (~st.por_done),
        .clr      (clr_all),
        .set      (set_all),
        .comb     (st.comb[gi]),
        .pol      (st.pol[gi]),
        .oe       (st.oe[gi]),
        .pt       (pt_sum[gi]),
        .pin_in   (io_in[gi]),
        .q        (flops[gi]),
        .pin_out  (io_out[gi]),
        .pin_oe_n (io_oe_n[gi])
      );
    end
  endgenerate

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
  assign flop_fb  = flops;
  assign por_done = st.por_done;

  property p_por_end;
    @(posedge mclk) disable iff (!rst_n)
      (!st.por_done && st.por_cnt == POR_LAST) |=> st.por_done ##1 st.por_done;
  endproperty
  a_por_end: assert property (p_por_end) else $error("power-up reset did not end on time");

  property p_por_clear;
    @(posedge mclk) disable iff (!rst_n)
      (!st.por_done && $past(!st.por_done)) |-> (flops == '0 && io_oe_n == '1);
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("flops not clear during power-up");

  property p_reg_out;
    @(posedge mclk) disable iff (!rst_n)
      (st.por_done && test_mode == MODE_NORMAL) |=> ((io_out ^ $past(flops ^ st.pol)) & ~$past(st.comb)) == '0;
  endproperty
  a_reg_out: assert property (p_reg_out) else $error("registered pin not register through polarity");

  property p_preload;
    @(posedge mclk) disable iff (!rst_n)
      (st.por_done && test_mode == MODE_PRELOAD && !clr_all && !set_all) |=> flops == $past(io_in);
  endproperty
  a_preload: assert property (p_preload) else $error("preload did not load pins");

  property p_observe_oe;
    @(posedge mclk) disable iff (!rst_n)
      (st.por_done && test_mode == MODE_OBSERVE) |=> io_oe_n == '0;
  endproperty
  a_observe_oe: assert property (p_observe_oe) else $error("observe did not enable outputs");

  property p_async_clear;
    @(posedge mclk) disable iff (!rst_n)
      clr_all |=> flops == '0;
  endproperty
  a_async_clear: assert property (p_async_clear) else $error("async reset did not clear bank");

  property p_test_registered;
    @(posedge mclk) disable iff (!rst_n)
      (st.por_done && test_mode != MODE_NORMAL) |=> io_out == $past(flops ^ st.pol);
  endproperty
  a_test_registered: assert property (p_test_registered) else $error("test mode output not registered");

  property p_pt_zero;
    @(posedge mclk) disable iff (!rst_n)
      (st.por_done && test_mode == MODE_OBSERVE && !clr_all && !set_all) |=> flops == $past(flops);
  endproperty
  a_pt_zero: assert property (p_pt_zero) else $error("product terms reached flops in observe");

  property p_comb_back;
    @(posedge mclk) disable iff (!rst_n)
      (test_mode == MODE_NORMAL) |=> ((io_out ^ $past(pt_sum ^ st.pol)) & $past(st.comb)) == '0;
  endproperty
  a_comb_back: assert property (p_comb_back) else $error("comb output not computed value");

  property p_ack_pulse;
    @(posedge mclk) disable iff (!rst_n)
      (req && !st.ack) |=> st.ack ##1 !st.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("wishbone ack not a single pulse");

endmodule

/* core/pupo_pkg.sv */
// constants, field layout and mode encoding for the power-up reset, preload and observe logic
// assumes one 250 MHz clock (mclk) and a classic wishbone register port
// Contract
// - after power-up every flip-flop is cleared low within 10 microseconds
// - pin level after reset is the cleared register passed through programmed polarity
// - preload loads every flip-flop, buried ones too, from the i/o pins
// - observe forces output enables on so every register shows on its pin
// - preloaded values that assert async reset or preset still act and overwrite
// - during preload or observe, combinatorial outputs are forced to registered mode
// - during test modes all product terms are forced to zero
// - after the test mode a plain combinatorial output returns to its computed value
package pupo_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PRELOAD,
    MODE_OBSERVE
  } pupo_mode_t;

  localparam int PUPO_N = 8;

  // register byte addresses
  localparam logic [7:0] ADR_COMB   = 8'h00;
  localparam logic [7:0] ADR_POL    = 8'h04;
  localparam logic [7:0] ADR_OE     = 8'h08;
  localparam logic [7:0] ADR_ASYNC  = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [7:0] ADR_FLOPS  = 8'h14;

  // async control field positions
  localparam int ARST_SRC_LSB = 0;
  localparam int ARST_EN_BIT  = 3;
  localparam int APRE_SRC_LSB = 4;
  localparam int APRE_EN_BIT  = 7;
  localparam int SRC_W        = 3;

  // status field positions
  localparam int POR_DONE_BIT = 0;
  localparam int MODE_LSB     = 1;

  // values after reset
  localparam logic [PUPO_N-1:0] COMB_RST  = 8'h00;
  localparam logic [PUPO_N-1:0] POL_RST   = 8'h00;
  localparam logic [PUPO_N-1:0] OE_RST    = 8'h00;
  localparam logic [7:0]        ASYNC_RST = 8'h00;

  // power-up reset time and its cycle count (longest time, rounded down)
  localparam int POWER_UP_RESET_TIME_NS = 10000;
  localparam int MCLK_PERIOD_NS         = 4;
  localparam int POR_CYCLES             = POWER_UP_RESET_TIME_NS / MCLK_PERIOD_NS;
  localparam int POR_CNT_W              = 12;
  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);

endpackage

/* core/pupo_cell.sv */
// one macrocell: its flip-flop, output polarity, comb/registered select and pin driver
// assumes the top supplies the mode, power-up hold and async reset/preset terms
`timescale 1ns/1ps
module pupo_cell (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // control
  input  wire pupo_pkg::pupo_mode_t mode,
  input  wire logic              por_busy,
  input  wire logic              clr,
  input  wire logic              set,
  // configuration
  input  wire logic              comb,
  input  wire logic              pol,
  input  wire logic              oe,
  // logic and pin
  input  wire logic              pt,
  input  wire logic              pin_in,
  output logic                   q,
  output logic                   pin_out,
  output logic                   pin_oe_n
);
  import pupo_pkg::*;

  typedef struct packed {
    logic q;
    logic out;
    logic oe_n;
  } pupo_cell_t;

  pupo_cell_t st;
  pupo_cell_t next_st;
  logic       pt_eff;

  always_comb begin
    next_st = st;
    // product terms read as zero in any test mode
    pt_eff = (mode == MODE_NORMAL) ? pt : 1'b0;
    if (por_busy) begin
      next_st.q = 1'b0;
    end else if (clr) begin
      next_st.q = 1'b0;
    end else if (set) begin
      next_st.q = 1'b1;
    end else begin
      case (mode)
        MODE_PRELOAD: next_st.q = pin_in;
        MODE_OBSERVE: next_st.q = st.q;
        default:      next_st.q = pt_eff;
      endcase
    end
    // registered path in test modes and for registered cells, computed value again in normal mode for comb cells
    if (mode != MODE_NORMAL || !comb) begin
      next_st.out = st.q ^ pol;
    end else begin
      next_st.out = pt_eff ^ pol;
    end
    // pins are released during power-up and preload so the tester can drive them
    if (por_busy || mode == MODE_PRELOAD) begin
      next_st.oe_n = 1'b1;
    end else if (mode == MODE_OBSERVE) begin
      next_st.oe_n = 1'b0;
    end else begin
      next_st.oe_n = ~oe;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '{q: 1'b0, out: 1'b0, oe_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign q        = st.q;
  assign pin_out  = st.out;
  assign pin_oe_n = st.oe_n;

endmodule

/* verif/pupo_tester.sv */
// tester model: drives the test mode and pin levels, resolves the shared io wire
// assumes the bench hands it the wanted mode and pin value just after a rising edge
`timescale 1ns/1ps
module pupo_tester (
  // clock and status
  input  wire logic                 mclk,
  input  wire logic                 por_done,
  // bench requests
  input  wire pupo_pkg::pupo_mode_t req_mode,
  input  wire logic [7:0]           req_val,
  // device side
  input  wire logic [7:0]           io_out,
  input  wire logic [7:0]           io_oe_n,
  output pupo_pkg::pupo_mode_t      test_mode,
  output logic [7:0]                io_in
);
  import pupo_pkg::*;
  logic [7:0] drv;
  // no mode change until reset is over, so setup is met before test edges
  always @(posedge mclk) begin
    test_mode <= por_done ? req_mode : MODE_NORMAL;
    drv <= req_val;
  end
  // the device wins where it drives, so a stale tester value never shows
  always_comb begin
    for (int i = 0; i < 8; i++) io_in[i] = io_oe_n[i] ? drv[i] : io_out[i];
  end
endmodule

/* verif/tb.sv */
// self-checking bench for the power-up reset, preload and observe logic
// assumes pupo_top and the tester model; bus is classic wishbone
`timescale 1ns/1ps
module tb;
  import pupo_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, por_done;
  logic [7:0]  wb_adr_i, pt_sum, io_in, io_out, io_oe_n, flop_fb, req_val;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  pupo_mode_t  test_mode, req_mode;
  int          num_errors = 0;
  int          n_tests = 0;
  always #2 mclk = ~mclk;
  pupo_top pupo_top_i (.mclk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .test_mode, .pt_sum, .io_in, .io_out, .io_oe_n,
    .flop_fb, .por_done);
  pupo_tester pupo_tester_i (.mclk, .por_done, .req_mode, .req_val, .io_out, .io_oe_n,
    .test_mode, .io_in);
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // ack and read data are taken at the rising edge where ack is seen high
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // mode and pins change together right after an edge, then settle for w falling edges
  task automatic pins(input pupo_mode_t m, input logic [7:0] v, input logic [7:0] p, input int w);
    @(posedge mclk);
    req_mode <= m;
    req_val <= v;
    pt_sum <= p;
    repeat (w) @(negedge mclk);
  endtask
  initial begin
    repeat (10000) @(posedge mclk);
    num_errors++;
    final_report();
  end
  initial begin
    int n;
    logic [7:0] tab [2][3];
    tab = '{'{8'h08, 8'h01, 8'h00}, '{8'h90, 8'h02, 8'hFF}};
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, pt_sum, req_val} = '0;
    wb_sel_i = 4'hF;
    req_mode = MODE_NORMAL;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk(flop_fb, 8'h00);
    chk(io_oe_n, 8'hFF);
    n = 0;
    while (por_done !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
      @(negedge mclk);
    end
    chk(n, POR_CYCLES);
    rd(ADR_STATUS, 32'h1);
    rd(8'h20, 32'h0);
    wr(ADR_POL, 32'hA5);
    wr(ADR_FLOPS, 32'h55);
    rd(ADR_POL, 32'hA5);
    rd(ADR_FLOPS, 32'h0);
    wr(ADR_OE, 32'hFF);
    pins(MODE_NORMAL, 8'h00, 8'h00, 5);
    chk(io_out, 8'hA5);
    wr(ADR_OE, 32'h0);
    wr(ADR_COMB, 32'h0F);
    pins(MODE_PRELOAD, 8'h3C, 8'hFF, 5);
    chk(flop_fb, 8'h3C);
    chk(io_oe_n, 8'hFF);
    pins(MODE_OBSERVE, 8'h00, 8'hFF, 5);
    chk(io_oe_n, 8'h00);
    chk(io_out, 8'h99);
    chk(flop_fb, 8'h3C);
    rd(ADR_STATUS, 32'h5);
    wr(ADR_OE, 32'hFF);
    pins(MODE_NORMAL, 8'h00, 8'h5A, 5);
    chk(io_out, 8'hFF);
    chk(flop_fb[7:4], 4'h5);
    wr(ADR_OE, 32'h0);
    // a one-edge preload that trips the clear or preset on purpose
    for (int i = 0; i < 2; i++) begin
      wr(ADR_ASYNC, {24'h0, tab[i][0]});
      // back to normal first: observe still drives the pins, which would win over the preload value
      pins(MODE_NORMAL, 8'h00, 8'h00, 2);
      pins(MODE_PRELOAD, tab[i][1], 8'h00, 0);
      pins(MODE_OBSERVE, 8'h00, 8'h00, 5);
      chk(flop_fb, tab[i][2]);
    end
    wr(ADR_ASYNC, 32'h0);
    final_report();
  end
endmodule
